// ### rtl/msm_regs.svh
// Constants for the MSI source device tag mapper
//
// Summary of operation
// - Core or untrusted writes never borrow a tag
// - Write to translator outside group is illegal
// - Illegal write: ignore, abort or unaliased tag
// - I/O MMU passes stream tag through unchanged
// - Stream tag to source tag is one-to-one
// - Source tag is stream tag plus offset A
// - Stream tag is RequesterID plus B shifted N
// - RequesterID width N is a parameter, default 16
// - No-MMU complex: RequesterID plus C shifted N
// - Other identifiers map by identity or offset
// - Mapping constants lock after initialization ends
// - Each MSI source gets a group-unique tag
// - Privileged masters pass without extra filtering
// - Tags for hot-plug locations reserved up front
// - Hot-plugged devices use the same static mapping
// - No discovery registers for tags or groups
// - All group translators see one tag per device
`ifndef MSM_REGS_SVH
`define MSM_REGS_SVH

// ----------------------------------------------------------------
// Field widths
// ----------------------------------------------------------------
`define MSM_ID_W 32
`define MSM_SRC_W 4
`define MSM_TGT_W 3
`define MSM_EVT_W 32
`define MSM_GRP_W 2
`define MSM_KIND_W 3

// ----------------------------------------------------------------
// Reset values of the mapping constants, default width N and the unaliased tag
// ----------------------------------------------------------------
`define MSM_RID_W_DEF 16
`define MSM_OFFSET_A_RST 32'h0000_0000
`define MSM_CONST_B_RST 32'h0000_0000
`define MSM_CONST_C_RST 32'h0000_0001
`define MSM_BOGUS_TAG 32'hFFFF_FFFF

// ----------------------------------------------------------------
// Constant load selector codes
// ----------------------------------------------------------------
`define MSM_SEL_A 2'h0
`define MSM_SEL_B 2'h1
`define MSM_SEL_C 2'h2

`endif

// ### rtl/msm_pkg.sv
// Types and shared arithmetic of the MSI source device tag mapper
`include "msm_regs.svh"

package msm_pkg;

    // Kind of master behind each ingress source port
    typedef enum logic [`MSM_KIND_W-1:0] {
        KIND_CORE,
        KIND_UNTRUSTED,
        KIND_TRUSTED,
        KIND_IOMMU,
        KIND_RC_IOMMU,
        KIND_RC_DIRECT
    } msm_kind_t;

    // Treatment of an illegal doorbell write
    typedef enum logic [1:0] {
        ILL_WRITE_IGNORE,
        ILL_ABORT,
        ILL_BOGUS_TAG
    } msm_illegal_t;

    // Completion code returned to the writer
    typedef enum logic [1:0] {
        RESP_OKAY,
        RESP_IGNORED,
        RESP_ABORT
    } msm_resp_t;

    // Incoming doorbell write
    typedef struct packed {
        logic [`MSM_SRC_W-1:0] src;
        logic [`MSM_ID_W-1:0] ident;
        logic [`MSM_TGT_W-1:0] target;
        logic [`MSM_EVT_W-1:0] event_id;
    } msm_req_t;

    // Write forwarded to an interrupt translator
    typedef struct packed {
        logic [`MSM_ID_W-1:0] tag;
        logic [`MSM_TGT_W-1:0] target;
        logic [`MSM_EVT_W-1:0] event_id;
    } msm_msi_t;

    // Identifier plus constant shifted by n; bit 32 flags overflow
    function automatic logic [`MSM_ID_W:0] msm_span_add(
        input logic [`MSM_ID_W-1:0] id,
        input logic [`MSM_ID_W-1:0] c,
        input int unsigned n
    );
        logic [2*`MSM_ID_W-1:0] wide;
        wide = ({{`MSM_ID_W{1'b0}}, c} << n) + {{`MSM_ID_W{1'b0}}, id};
        return {|wide[2*`MSM_ID_W-1:`MSM_ID_W], wide[`MSM_ID_W-1:0]};
    endfunction

endpackage

// ### rtl/msm_tag_calc.sv
// Combinational source device tag derivation for one doorbell write
`timescale 1ns/1ps
`default_nettype none
`include "msm_regs.svh"

module msm_tag_calc
    import msm_pkg::*;
#(
    parameter int unsigned RID_W = `MSM_RID_W_DEF
) (
    // Source description
    input wire msm_kind_t kind,
    input wire logic [`MSM_ID_W-1:0] ident,
    // Mapping constants
    input wire logic [`MSM_ID_W-1:0] offset_a,
    input wire logic [`MSM_ID_W-1:0] const_b,
    input wire logic [`MSM_ID_W-1:0] const_c,
    // Result
    output logic [`MSM_ID_W-1:0] tag,
    output logic overflow
);

    logic [`MSM_ID_W-1:0] rid_zx;
    logic [`MSM_ID_W:0] stream_sum;
    logic [`MSM_ID_W:0] tag_sum;

    // Zero-extended RequesterID low N bits
    always_comb begin
        rid_zx = '0;
        for (int i = 0; i < RID_W && i < `MSM_ID_W; i++) begin
            rid_zx[i] = ident[i];
        end
    end

    // Per-kind linear mapping, never a table
    always_comb begin
        stream_sum = '0;
        tag_sum = '0;
        case (kind)
            KIND_IOMMU: begin
                // Stream tag arrives unmodified from the I/O MMU
                tag_sum = msm_span_add(ident, offset_a, 0);
            end
            KIND_RC_IOMMU: begin
                stream_sum = msm_span_add(rid_zx, const_b, RID_W);
                tag_sum = msm_span_add(stream_sum[`MSM_ID_W-1:0], offset_a, 0);
                tag_sum[`MSM_ID_W] = tag_sum[`MSM_ID_W] | stream_sum[`MSM_ID_W];
            end
            KIND_RC_DIRECT: begin
                tag_sum = msm_span_add(rid_zx, const_c, RID_W);
            end
            KIND_TRUSTED: begin
                tag_sum = {1'b0, ident};
            end
            default: begin
                tag_sum = '0;
            end
        endcase
    end

    // Wrapped sums would alias another tag, so flag them
    assign tag = tag_sum[`MSM_ID_W-1:0];
    assign overflow = tag_sum[`MSM_ID_W];

endmodule
`default_nettype wire

// ### rtl/msm_mapper.sv
// MSI doorbell ingress: source classification and tag mapping
`timescale 1ns/1ps
`default_nettype none
`include "msm_regs.svh"

module msm_mapper
    import msm_pkg::*;
#(
    parameter int unsigned NSRC = 8,
    parameter int unsigned NITS = 4,
    parameter int unsigned RID_W = `MSM_RID_W_DEF,
    parameter msm_illegal_t ILLEGAL_MODE = ILL_WRITE_IGNORE,
    // Kind of each source port, KIND_W bits per port
    parameter logic [NSRC*`MSM_KIND_W-1:0] SRC_KIND = '0,
    // Translator group of each source port
    parameter logic [NSRC*`MSM_GRP_W-1:0] SRC_GROUP = '0,
    // Translator group of each interrupt translator
    parameter logic [NITS*`MSM_GRP_W-1:0] ITS_GROUP = '0,
    // Highest tag value legitimately assignable, hot-plug span included
    parameter logic [`MSM_ID_W-1:0] TAG_LIMIT = 32'hFFFF_FFFE
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Doorbell writes from the interconnect
    input wire logic req_valid,
    input wire msm_req_t req,
    // Firmware constant loading during initialization
    input wire logic init_done,
    input wire logic cfg_we,
    input wire logic [1:0] cfg_sel,
    input wire logic [`MSM_ID_W-1:0] cfg_data,
    // Writes forwarded to the translators
    output logic msi_valid,
    output msm_msi_t msi,
    // Completion to the writer
    output logic resp_valid,
    output msm_resp_t resp,
    // Status
    output logic cfg_locked,
    output logic cfg_refused,
    output logic illegal_seen,
    output logic [15:0] illegal_count
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic {
        CFG_OPEN,
        CFG_LOCKED
    } msm_cfg_state_t;

    msm_cfg_state_t cfg_state_reg;
    msm_cfg_state_t cfg_state_next;
    logic [`MSM_ID_W-1:0] offset_a_reg;
    logic [`MSM_ID_W-1:0] const_b_reg;
    logic [`MSM_ID_W-1:0] const_c_reg;
    logic cfg_refused_reg;
    logic msi_valid_reg;
    msm_msi_t msi_reg;
    logic resp_valid_reg;
    msm_resp_t resp_reg;
    logic illegal_seen_reg;
    logic [15:0] illegal_count_reg;

    msm_kind_t src_kind;
    logic src_known;
    logic tgt_known;
    logic [`MSM_GRP_W-1:0] src_grp;
    logic [`MSM_GRP_W-1:0] tgt_grp;
    logic [`MSM_ID_W-1:0] calc_tag;
    logic calc_ovf;
    logic not_msi_source;
    logic wrong_group;
    logic tag_unsafe;
    logic is_illegal;
    logic accept;

    // ----------------------------------------------------------------
    // Table lookups
    // ----------------------------------------------------------------

    // Kind of the writing port from the design-time table
    function automatic msm_kind_t kind_of(input logic [`MSM_SRC_W-1:0] s);
        msm_kind_t k;
        k = KIND_UNTRUSTED;
        for (int i = 0; i < NSRC; i++) begin
            if (s == `MSM_SRC_W'(i)) begin
                k = msm_kind_t'(SRC_KIND[i*`MSM_KIND_W +: `MSM_KIND_W]);
            end
        end
        return k;
    endfunction

    // Group of the writing port
    function automatic logic [`MSM_GRP_W-1:0] src_group_of(
        input logic [`MSM_SRC_W-1:0] s
    );
        logic [`MSM_GRP_W-1:0] g;
        g = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (s == `MSM_SRC_W'(i)) begin
                g = SRC_GROUP[i*`MSM_GRP_W +: `MSM_GRP_W];
            end
        end
        return g;
    endfunction

    // Group of the addressed translator
    function automatic logic [`MSM_GRP_W-1:0] its_group_of(
        input logic [`MSM_TGT_W-1:0] t
    );
        logic [`MSM_GRP_W-1:0] g;
        g = '0;
        for (int i = 0; i < NITS; i++) begin
            if (t == `MSM_TGT_W'(i)) begin
                g = ITS_GROUP[i*`MSM_GRP_W +: `MSM_GRP_W];
            end
        end
        return g;
    endfunction

    // Classify the write by its port; group tables have no read path
    always_comb begin
        src_kind = kind_of(req.src);
        src_known = (32'(req.src) < NSRC);
        tgt_known = (32'(req.target) < NITS);
        src_grp = src_group_of(req.src);
        tgt_grp = its_group_of(req.target);
    end

    // ----------------------------------------------------------------
    // Tag derivation
    // ----------------------------------------------------------------

    // Tag depends only on source and identifier, never on target
    msm_tag_calc #(
        .RID_W(RID_W)
    ) u_tag_calc (
        .kind(src_kind),
        .ident(req.ident),
        .offset_a(offset_a_reg),
        .const_b(const_b_reg),
        .const_c(const_c_reg),
        .tag(calc_tag),
        .overflow(calc_ovf)
    );

    // ----------------------------------------------------------------
    // Legality checks
    // ----------------------------------------------------------------

    // Cores, non-MSI masters and unlisted kind codes may not post writes
    always_comb begin
        not_msi_source = 1'b0;
        if (!src_known) begin
            not_msi_source = 1'b1;
        end else if (!(src_kind inside {KIND_TRUSTED, KIND_IOMMU,
                KIND_RC_IOMMU, KIND_RC_DIRECT})) begin
            not_msi_source = 1'b1;
        end
    end

    // Trusted masters are checked for group and tag limit only
    assign wrong_group = !tgt_known || (src_grp != tgt_grp);

    // Whole identifier span is mapped, so hot-plug slots need no table
    // entries; anything past the reserved span or wrapping is refused
    assign tag_unsafe = calc_ovf || (calc_tag > TAG_LIMIT);

    assign is_illegal = not_msi_source || wrong_group || tag_unsafe;
    assign accept = clk_en && req_valid;

    // ----------------------------------------------------------------
    // Constant lock state machine
    // ----------------------------------------------------------------

    // Open until initialization ends, then locked for good
    always_comb begin
        case (cfg_state_reg)
            CFG_OPEN: begin
                cfg_state_next = init_done ? CFG_LOCKED : CFG_OPEN;
            end
            CFG_LOCKED: begin
                cfg_state_next = CFG_LOCKED;
            end
            default: begin
                cfg_state_next = CFG_LOCKED;
            end
        endcase
    end

    // Lock state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_state_reg <= CFG_OPEN;
        end else if (clk_en) begin
            cfg_state_reg <= cfg_state_next;
        end
    end

    // Mapping constants, loadable by firmware any number of times until the lock closes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            offset_a_reg <= `MSM_OFFSET_A_RST;
            const_b_reg <= `MSM_CONST_B_RST;
            const_c_reg <= `MSM_CONST_C_RST;
        end else if (clk_en && cfg_we && cfg_state_reg == CFG_OPEN) begin
            case (cfg_sel)
                `MSM_SEL_A: begin
                    offset_a_reg <= cfg_data;
                end
                `MSM_SEL_B: begin
                    const_b_reg <= cfg_data;
                end
                `MSM_SEL_C: begin
                    const_c_reg <= cfg_data;
                end
                default: begin
                    offset_a_reg <= offset_a_reg;
                end
            endcase
        end
    end

    // Late load attempts are dropped and reported for one cycle
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_refused_reg <= 1'b0;
        end else if (clk_en) begin
            cfg_refused_reg <= cfg_we && cfg_state_reg == CFG_LOCKED;
        end
    end

    // ----------------------------------------------------------------
    // Forwarding to the translators
    // ----------------------------------------------------------------

    // One-cycle forward; illegal writes follow the build-time policy
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            msi_valid_reg <= 1'b0;
            msi_reg <= '0;
        end else if (clk_en) begin
            msi_valid_reg <= 1'b0;
            if (req_valid && !is_illegal) begin
                msi_valid_reg <= 1'b1;
                msi_reg.tag <= calc_tag;
                msi_reg.target <= req.target;
                msi_reg.event_id <= req.event_id;
            end else if (req_valid && ILLEGAL_MODE == ILL_BOGUS_TAG) begin
                // Reserved tag above the legal span aliases nobody
                msi_valid_reg <= 1'b1;
                msi_reg.tag <= `MSM_BOGUS_TAG;
                msi_reg.target <= req.target;
                msi_reg.event_id <= req.event_id;
            end
        end
    end

    // ----------------------------------------------------------------
    // Completion to the writer
    // ----------------------------------------------------------------

    // Every accepted write gets exactly one completion
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            resp_valid_reg <= 1'b0;
            resp_reg <= RESP_OKAY;
        end else if (clk_en) begin
            resp_valid_reg <= req_valid;
            if (req_valid) begin
                if (!is_illegal || ILLEGAL_MODE == ILL_BOGUS_TAG) begin
                    resp_reg <= RESP_OKAY;
                end else if (ILLEGAL_MODE == ILL_ABORT) begin
                    resp_reg <= RESP_ABORT;
                end else begin
                    resp_reg <= RESP_IGNORED;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Illegal write statistics
    // ----------------------------------------------------------------

    // Pulse and saturating count of illegal writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            illegal_seen_reg <= 1'b0;
            illegal_count_reg <= 16'h0000;
        end else if (clk_en) begin
            illegal_seen_reg <= accept && is_illegal;
            if (accept && is_illegal && illegal_count_reg != 16'hFFFF) begin
                illegal_count_reg <= illegal_count_reg + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign msi_valid = msi_valid_reg;
    assign msi = msi_reg;
    assign resp_valid = resp_valid_reg;
    assign resp = resp_reg;
    assign cfg_locked = (cfg_state_reg == CFG_LOCKED);
    assign cfg_refused = cfg_refused_reg;
    assign illegal_seen = illegal_seen_reg;
    assign illegal_count = illegal_count_reg;

endmodule
`default_nettype wire

// ### sim/msm_mapper_checker.sv
// Concurrent checks on the ports of the MSI source tag mapper
`timescale 1ns/1ps
`default_nettype none

module msm_mapper_checker
    import msm_pkg::*;
#(
    parameter int unsigned NSRC = 8,
    parameter int unsigned NITS = 4,
    parameter msm_illegal_t ILLEGAL_MODE = ILL_WRITE_IGNORE
) (
    // Clock and control
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic init_done,
    input wire logic cfg_we,
    // Request side
    input wire logic req_valid,
    input wire msm_req_t req,
    // Answer side
    input wire logic msi_valid,
    input wire msm_msi_t msi,
    input wire logic resp_valid,
    input wire msm_resp_t resp,
    input wire logic cfg_locked,
    input wire logic cfg_refused,
    input wire logic illegal_seen,
    input wire logic [15:0] illegal_count
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // Request and answer steps
    // ----------------------------------------
    sequence s_take;
        clk_en && req_valid;
    endsequence
    sequence s_ans;
        resp_valid && (!msi_valid || resp == RESP_OKAY);
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    take_answer_a: assert property (s_take |=> s_ans)
        else $error("request without answer one cycle later");
    idle_quiet_a: assert property (clk_en && !req_valid |=> !resp_valid && !msi_valid)
        else $error("answer without a request");
    fwd_ok_a: assert property (msi_valid |-> resp_valid && resp == RESP_OKAY)
        else $error("forwarded write lacks an okay completion");
    bad_src_a: assert property ((s_take and (req.src >= NSRC))
        |=> illegal_seen && (!msi_valid || msi.tag == 32'hFFFF_FFFF))
        else $error("unknown source was not treated as illegal");
    bad_tgt_a: assert property ((s_take and (req.target >= NITS)) |=> illegal_seen)
        else $error("write to missing translator not flagged");
    fields_pass_a: assert property (s_take |=> !msi_valid
        || (msi.target == $past(req.target) && msi.event_id == $past(req.event_id)))
        else $error("target or event altered on the way");
    ill_drop_a: assert property (illegal_seen
        |-> resp_valid && (ILLEGAL_MODE == ILL_BOGUS_TAG || !msi_valid))
        else $error("illegal write reached a translator");
    lock_set_a: assert property (clk_en && init_done |=> cfg_locked [*2])
        else $error("constants not locked after initialization");
    refuse_a: assert property (clk_en |=> cfg_refused == $past(cfg_we && cfg_locked))
        else $error("late constant write not refused");
    count_step_a: assert property ($past(clk_en) && illegal_seen && $past(illegal_count) != 16'hFFFF
        |-> illegal_count == $past(illegal_count) + 16'h1)
        else $error("illegal counter did not step");
endmodule

`default_nettype wire

// ### sim/msm_its_model.sv
// Interrupt translator stand-in that takes every forwarded write
`timescale 1ns/1ps
`default_nettype none

module msm_its_model
    import msm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Writes from the mapper
    input wire logic msi_valid,
    input wire msm_msi_t msi,
    // Observation
    output logic [15:0] rx_count
);
    // Never stalls; counts each write it is handed whose target is below 4
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_count <= 16'h0;
        end else if (msi_valid && msi.target < 3'h4) begin
            rx_count <= rx_count + 16'h1;
        end
    end
endmodule

`default_nettype wire

// ### sim/msi_source_id_mapper_tb_top.sv
// Self-checking bench of the MSI source tag mapper
`timescale 1ns/1ps
`default_nettype none

module msi_source_id_mapper_tb_top;
    import msm_pkg::*;
    localparam int RIDW = 8;
    localparam logic [23:0] KINDS = {3'h2, 3'h3, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    localparam logic [15:0] SGRP = 16'h1000;
    localparam logic [7:0] IGRP = 8'h50;
    logic ref_clk = 0, resetn = 0, clk_en = 1, req_valid = 0, init_done = 0, cfg_we = 0;
    logic [1:0] cfg_sel = 2'h0;
    logic [31:0] cfg_data = 32'h0;
    msm_req_t req = '0;
    logic msi_valid, resp_valid, cfg_locked, cfg_refused, illegal_seen, bg_mv;
    msm_msi_t msi, bg_msi;
    msm_resp_t resp, ab_resp;
    logic [15:0] illegal_count, rx_count;
    logic e_rv = 0, e_mv = 0, e_lock = 0, e_ref = 0, e_ill = 0;
    msm_resp_t e_resp = RESP_OKAY;
    msm_msi_t e_msi = '0, e_bmsi = '0;
    logic [15:0] e_cnt = 16'h0;
    logic [31:0] ca = 32'h0, cb = 32'h0, cc = 32'h1;
    int n_fwd = 0, err_count = 0, checks_done = 0;

    // Clock
    always #2.5 ref_clk = ~ref_clk;

    msm_mapper #(.NSRC(8), .NITS(4), .RID_W(RIDW), .ILLEGAL_MODE(ILL_WRITE_IGNORE),
        .SRC_KIND(KINDS), .SRC_GROUP(SGRP), .ITS_GROUP(IGRP), .TAG_LIMIT(32'hFFFF_FFFE)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .init_done(init_done), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
        .msi_valid(msi_valid), .msi(msi), .resp_valid(resp_valid), .resp(resp),
        .cfg_locked(cfg_locked), .cfg_refused(cfg_refused), .illegal_seen(illegal_seen),
        .illegal_count(illegal_count));

    msm_its_model u_its (.ref_clk(ref_clk), .resetn(resetn), .msi_valid(msi_valid), .msi(msi),
        .rx_count(rx_count));

    // Same mapper built with the abort and the unaliased tag policies
    msm_mapper #(.NSRC(8), .NITS(4), .RID_W(RIDW), .ILLEGAL_MODE(ILL_ABORT),
        .SRC_KIND(KINDS), .SRC_GROUP(SGRP), .ITS_GROUP(IGRP), .TAG_LIMIT(32'hFFFF_FFFE)) u_dut_ab (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .init_done(init_done), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
        .msi_valid(), .msi(), .resp_valid(), .resp(ab_resp), .cfg_locked(), .cfg_refused(),
        .illegal_seen(), .illegal_count());
    msm_mapper #(.NSRC(8), .NITS(4), .RID_W(RIDW), .ILLEGAL_MODE(ILL_BOGUS_TAG),
        .SRC_KIND(KINDS), .SRC_GROUP(SGRP), .ITS_GROUP(IGRP), .TAG_LIMIT(32'hFFFF_FFFE)) u_dut_bg (
        .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .init_done(init_done), .cfg_we(cfg_we), .cfg_sel(cfg_sel), .cfg_data(cfg_data),
        .msi_valid(bg_mv), .msi(bg_msi), .resp_valid(), .resp(), .cfg_locked(), .cfg_refused(),
        .illegal_seen(), .illegal_count());

    // ----------------------------------------
    // Reference model and checks
    // ----------------------------------------
    // Bit 32 set means the write is illegal
    function automatic logic [32:0] model(input msm_req_t r);
        logic [63:0] v;
        logic [63:0] n;
        logic [2:0] k;
        n = 64'(r.ident[RIDW-1:0]);
        k = KINDS[3*r.src[2:0] +: 3];
        if (r.src >= 8 || r.target >= 4 || k < 3'h2) return {1'b1, 32'h0};
        if (SGRP[2*r.src[2:0] +: 2] != IGRP[2*r.target[1:0] +: 2]) return {1'b1, 32'h0};
        case (k)
            3'h2: v = 64'(r.ident);
            3'h3: v = 64'(r.ident) + 64'(ca);
            3'h4: v = n + (64'(cb) << RIDW) + 64'(ca);
            default: v = n + (64'(cc) << RIDW);
        endcase
        return {v > 64'hFFFF_FFFE, v[31:0]};
    endfunction

    task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic check_out();
        chk("resp_valid", e_rv, resp_valid);
        if (e_rv) chk("resp", e_resp, resp);
        if (e_rv) chk("resp abort", e_ill ? RESP_ABORT : RESP_OKAY, ab_resp);
        chk("msi_valid bogus", e_rv, bg_mv);
        if (e_rv) chk("msi bogus", e_bmsi, bg_msi);
        chk("msi_valid", e_mv, msi_valid);
        if (e_mv) chk("msi", e_msi, msi);
        chk("illegal_seen", e_ill, illegal_seen);
        chk("illegal_count", e_cnt, illegal_count);
        chk("cfg_locked", e_lock, cfg_locked);
        chk("cfg_refused", e_ref, cfg_refused);
    endtask

    // Check last edge, then drive a random request for the next one
    task automatic step(input logic v, input logic ce);
        logic [32:0] m;
        check_out();
        clk_en = ce;
        req_valid = v;
        req.src = 4'($urandom_range(9));
        req.target = 3'($urandom_range(4));
        req.ident = $urandom;
        req.event_id = $urandom;
        m = model(req);
        if (ce) begin
            e_rv = v;
            e_mv = v && !m[32];
            e_ill = v && m[32];
            e_ref = cfg_we && e_lock;
            if (v) begin
                e_resp = m[32] ? RESP_IGNORED : RESP_OKAY;
                e_bmsi = '{m[32] ? 32'hFFFF_FFFF : m[31:0], req.target, req.event_id};
                if (!m[32]) begin
                    e_msi = '{m[31:0], req.target, req.event_id};
                    n_fwd++;
                end else if (e_cnt != 16'hFFFF) begin
                    e_cnt++;
                end
            end
            if (cfg_we && !e_lock) begin
                case (cfg_sel)
                    2'h0: ca = cfg_data;
                    2'h1: cb = cfg_data;
                    2'h2: cc = cfg_data;
                    default: ;
                endcase
            end
            if (init_done) e_lock = 1;
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h9466));
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        resetn = 1;
        // Load every constant selector, the spare one too, beside live requests
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk);
            cfg_we = 1;
            cfg_sel = 2'(i);
            cfg_data = (i == 0) ? $urandom : $urandom_range(16'hFFFF);
            step(1, 1);
        end
        @(negedge ref_clk);
        cfg_we = 0;
        step(0, 1);
        repeat (150) begin
            @(negedge ref_clk);
            step(1, 1);
        end
        // Frozen clock enable ignores a request
        @(negedge ref_clk);
        step(0, 1);
        @(negedge ref_clk);
        step(1, 0);
        // Write beside lock is taken, later ones refused
        @(negedge ref_clk);
        init_done = 1;
        cfg_we = 1;
        cfg_sel = 2'h0;
        cfg_data = $urandom;
        step(1, 1);
        @(negedge ref_clk);
        cfg_data = $urandom;
        step(1, 1);
        @(negedge ref_clk);
        cfg_we = 0;
        step(1, 1);
        repeat (150) begin
            @(negedge ref_clk);
            step(1, 1);
        end
        repeat (2) begin
            @(negedge ref_clk);
            step(0, 1);
        end
        chk("rx_count", 72'(n_fwd), rx_count);
        final_report();
    end

    // Watchdog
    initial begin
        #(2000 * 5);
        err_count++;
        final_report();
    end
endmodule

bind msm_mapper msm_mapper_checker #(.NSRC(NSRC), .NITS(NITS), .ILLEGAL_MODE(ILLEGAL_MODE)) u_chk (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .init_done(init_done), .cfg_we(cfg_we),
    .req_valid(req_valid), .req(req), .msi_valid(msi_valid), .msi(msi),
    .resp_valid(resp_valid), .resp(resp), .cfg_locked(cfg_locked), .cfg_refused(cfg_refused),
    .illegal_seen(illegal_seen), .illegal_count(illegal_count));

`default_nettype wire
